// *** logic/ipf_defs.vh ***
// Constants for the interrupt priority field block: register map, slot field
// positions, reset values and bus encodings. Included by every design file.
// Contract
// - Slot 3 priority sits at bits 28:26, subpriority at bits 25:24.
// - Slot 2 priority sits at bits 20:18, subpriority at bits 17:16.
// - Slot 1 priority sits at bits 12:10, subpriority at bits 9:8.
// - Slot 0 priority sits at bits 4:2, subpriority at bits 1:0.
// - A zero priority field disables the source; it is never presented.
// - Nonzero priority one to seven is the level equal to its value.
// - Subpriority field gives levels zero to three directly, every slot.
// - Bits 31:29, 23:21, 15:13, 7:5 ignore writes and read zero.
// - Implemented fields are read/write and clear at reset, disabling all sources.
// - A rising request sets its sticky pending flag; a flag word write also loads it, so software can set it without request.
// - A per-source enable bit gates each request regardless of priority.
`ifndef IPF_DEFS_VH
`define IPF_DEFS_VH

// Word index map, byte address is four times the index.
`define IPF_PRIO_IDX        6'h00
`define IPF_FLAG_IDX        6'h10
`define IPF_ENABLE_IDX      6'h11
`define IPF_STATUS_IDX      6'h12
`define IPF_IDX_W           6

// Slot field positions.
`define IPF_SLOT3_PRIO_LSB  26
`define IPF_SLOT3_SUB_LSB   24
`define IPF_SLOT2_PRIO_LSB  18
`define IPF_SLOT2_SUB_LSB   16
`define IPF_SLOT1_PRIO_LSB  10
`define IPF_SLOT1_SUB_LSB   8
`define IPF_SLOT0_PRIO_LSB  2
`define IPF_SLOT0_SUB_LSB   0
`define IPF_PRIO_W          3
`define IPF_SUB_W           2
`define IPF_SLOTS_PER_REG   4
`define IPF_IMPL_MASK       32'h1F1F1F1F
`define IPF_PRIO_OFF        3'h0

// Reset values.
`define IPF_WORD_RST        32'h00000000

// Status word layout.
`define IPF_STAT_VALID_BIT  31
`define IPF_STAT_LEVEL_LSB  16
`define IPF_STAT_SUB_LSB    12
`define IPF_STAT_SRC_LSB    0

// Bus encodings.
`define IPF_HTRANS_NONSEQ   2'h2
`define IPF_HRESP_OKAY      1'h0

`endif

// *** logic/ipf_sync.v ***
// Two-stage synchroniser for a vector of asynchronous request pins.
// Assumes each bit is a slow level held for at least two clock periods.
`timescale 1ns/10ps
`include "ipf_defs.vh"
module ipf_sync #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input  wire             hclk,
    input  wire             hresetn,
    // Data
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] stable_q;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q   <= {WIDTH{1'b0}};
            stable_q <= {WIDTH{1'b0}};
        end else begin
            meta_q   <= async_in;
            stable_q <= meta_q;
        end
    end

    assign sync_out = stable_q;
endmodule

// *** logic/ipf_arbiter.v ***
// Combinational ranking of pending, enabled sources by priority and subpriority.
// Assumes flat vectors of per-source fields from the same clock domain.
`timescale 1ns/10ps
`include "ipf_defs.vh"
module ipf_arbiter #(
    parameter NUM_SRC = 8,
    parameter IDX_W   = 3
) (
    // Candidates
    input  wire [NUM_SRC-1:0]            req,
    input  wire [`IPF_PRIO_W*NUM_SRC-1:0] levels,
    input  wire [`IPF_SUB_W*NUM_SRC-1:0]  subs,
    // Winner
    output reg                           win_valid,
    output reg  [IDX_W-1:0]              win_idx,
    output reg  [`IPF_PRIO_W-1:0]        win_level,
    output reg  [`IPF_SUB_W-1:0]         win_sub
);
    integer i;
    reg [`IPF_PRIO_W-1:0] lvl;
    reg [`IPF_SUB_W-1:0]  sb;

    // Strict comparison keeps the lowest index on a full tie.
    always @* begin
        win_valid = 1'b0;
        win_idx   = {IDX_W{1'b0}};
        win_level = {`IPF_PRIO_W{1'b0}};
        win_sub   = {`IPF_SUB_W{1'b0}};
        lvl       = {`IPF_PRIO_W{1'b0}};
        sb        = {`IPF_SUB_W{1'b0}};
        for (i = 0; i < NUM_SRC; i = i + 1) begin
            lvl = levels[`IPF_PRIO_W*i +: `IPF_PRIO_W];
            sb  = subs[`IPF_SUB_W*i +: `IPF_SUB_W];
            if (req[i] && (lvl != `IPF_PRIO_OFF) &&
                (!win_valid || ({lvl, sb} > {win_level, win_sub}))) begin
                win_valid = 1'b1;
                win_idx   = i[IDX_W-1:0];
                win_level = lvl;
                win_sub   = sb;
            end
        end
    end
endmodule

// *** logic/ipf_top.v ***
// Interrupt priority field block: priority registers, pending flags, enables
// and the ranking of pending sources, reached as an AHB-Lite slave.
// Assumes request pins are asynchronous levels and the processor samples the
// presented source on hclk.
//
// Local design decisions: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps
`include "ipf_defs.vh"
module ipf_top #(
    parameter NUM_PRIO_REGS = 2,
    parameter NUM_SRC       = 8,
    parameter IDX_W         = 3
) (
    // Clock and reset
    input  wire                   hclk,
    input  wire                   hresetn,
    // AHB-Lite slave
    input  wire                   hsel,
    input  wire [31:0]            haddr,
    input  wire [1:0]             htrans,
    input  wire                   hwrite,
    input  wire [2:0]             hsize,
    input  wire [31:0]            hwdata,
    input  wire                   hready,
    output wire                   hreadyout,
    output wire                   hresp,
    output wire [31:0]            hrdata,
    // Interrupt request pins
    input  wire [NUM_SRC-1:0]     irq_pins,
    // Presented interrupt towards the processor
    output wire                   present_valid,
    output wire [IDX_W-1:0]       present_src,
    output wire [`IPF_PRIO_W-1:0] present_level,
    output wire [`IPF_SUB_W-1:0]  present_sub
);
    localparam [`IPF_IDX_W-1:0] PRIO_CNT = NUM_PRIO_REGS[`IPF_IDX_W-1:0];

    // One-hot kinds of word that the index decoder tells apart. Write and read
    // paths share the decoder so that the two can never disagree on the map.
    localparam [3:0] KIND_NONE   = 4'h0;
    localparam [3:0] KIND_PRIO   = 4'h1;
    localparam [3:0] KIND_FLAG   = 4'h2;
    localparam [3:0] KIND_ENABLE = 4'h4;
    localparam [3:0] KIND_STATUS = 4'h8;

    // Register state.
    reg [32*NUM_PRIO_REGS-1:0] prio_q;
    reg [32*NUM_PRIO_REGS-1:0] prio_d;
    reg [NUM_SRC-1:0]          flag_q;
    reg [NUM_SRC-1:0]          flag_d;
    reg [NUM_SRC-1:0]          enable_q;
    reg [NUM_SRC-1:0]          enable_d;

    // Bus pipeline state.
    reg                        wr_pend_q;
    reg [`IPF_IDX_W-1:0]       wr_idx_q;
    reg [31:0]                 hrdata_q;
    reg [31:0]                 hrdata_d;

    // Request edge detection.
    wire [NUM_SRC-1:0]         req_sync;
    reg  [NUM_SRC-1:0]         req_dly_q;
    wire [NUM_SRC-1:0]         req_rise;

    // Per-source fields and ranking.
    reg  [`IPF_PRIO_W*NUM_SRC-1:0] levels;
    reg  [`IPF_SUB_W*NUM_SRC-1:0]  subs;
    wire                       win_valid;
    wire [IDX_W-1:0]           win_idx;
    wire [`IPF_PRIO_W-1:0]     win_level;
    wire [`IPF_SUB_W-1:0]      win_sub;
    reg                        present_valid_q;
    reg  [IDX_W-1:0]           present_src_q;
    reg  [`IPF_PRIO_W-1:0]     present_level_q;
    reg  [`IPF_SUB_W-1:0]      present_sub_q;

    // Bus decode.
    wire                       take;
    wire [`IPF_IDX_W-1:0]      addr_idx;
    wire [3:0]                 wr_kind;
    wire [3:0]                 rd_kind;

    integer s;

    // Priority level of a slot within one register word.
    function [`IPF_PRIO_W-1:0] slot_prio;
        input [31:0] word;
        input [1:0]  slot;
        begin
            case (slot)
                2'h3: slot_prio = word[`IPF_SLOT3_PRIO_LSB +: `IPF_PRIO_W];
                2'h2: slot_prio = word[`IPF_SLOT2_PRIO_LSB +: `IPF_PRIO_W];
                2'h1: slot_prio = word[`IPF_SLOT1_PRIO_LSB +: `IPF_PRIO_W];
                default: slot_prio = word[`IPF_SLOT0_PRIO_LSB +: `IPF_PRIO_W];
            endcase
        end
    endfunction

    // Subpriority of a slot within one register word.
    function [`IPF_SUB_W-1:0] slot_sub;
        input [31:0] word;
        input [1:0]  slot;
        begin
            case (slot)
                2'h3: slot_sub = word[`IPF_SLOT3_SUB_LSB +: `IPF_SUB_W];
                2'h2: slot_sub = word[`IPF_SLOT2_SUB_LSB +: `IPF_SUB_W];
                2'h1: slot_sub = word[`IPF_SLOT1_SUB_LSB +: `IPF_SUB_W];
                default: slot_sub = word[`IPF_SLOT0_SUB_LSB +: `IPF_SUB_W];
            endcase
        end
    endfunction

    // Widens a per-source vector into a bus word, upper bits zero.
    function [31:0] widen;
        input [NUM_SRC-1:0] bits;
        begin
            widen = `IPF_WORD_RST;
            widen[NUM_SRC-1:0] = bits;
        end
    endfunction

    // Decodes a word index into one of the kinds above.
    // Unmapped words give none, so they read zero and ignore writes.
    function [3:0] word_kind;
        input [`IPF_IDX_W-1:0] idx;
        begin
            if (idx < PRIO_CNT) begin
                word_kind = KIND_PRIO;
            end else if (idx == `IPF_FLAG_IDX) begin
                word_kind = KIND_FLAG;
            end else if (idx == `IPF_ENABLE_IDX) begin
                word_kind = KIND_ENABLE;
            end else if (idx == `IPF_STATUS_IDX) begin
                word_kind = KIND_STATUS;
            end else begin
                word_kind = KIND_NONE;
            end
        end
    endfunction

    // Packs the presented winner into the read-only status word.
    function [31:0] status_word;
        input                   valid;
        input [IDX_W-1:0]       src;
        input [`IPF_PRIO_W-1:0] level;
        input [`IPF_SUB_W-1:0]  sub;
        begin
            status_word                                     = `IPF_WORD_RST;
            status_word[`IPF_STAT_VALID_BIT]                = valid;
            status_word[`IPF_STAT_LEVEL_LSB +: `IPF_PRIO_W] = level;
            status_word[`IPF_STAT_SUB_LSB +: `IPF_SUB_W]    = sub;
            status_word[`IPF_STAT_SRC_LSB +: IDX_W]         = src;
        end
    endfunction

    // Request pins are asynchronous; two flip-flops stand before any logic.
    ipf_sync #(
        .WIDTH (NUM_SRC)
    ) u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in (irq_pins),
        .sync_out (req_sync)
    );

    assign req_rise = req_sync & ~req_dly_q;

    // AHB-Lite: zero wait states, always OKAY.
    assign take      = hsel && hready && (htrans == `IPF_HTRANS_NONSEQ);
    assign addr_idx  = haddr[`IPF_IDX_W+1:2];
    // Writes decode the captured index, reads the live address phase.
    assign wr_kind   = word_kind(wr_idx_q);
    assign rd_kind   = word_kind(addr_idx);
    assign hreadyout = 1'b1;
    assign hresp     = `IPF_HRESP_OKAY;
    assign hrdata    = hrdata_q;

    // Next register values; a hardware flag set wins over a software clear.
    // Status and unmapped words keep every register as it is.
    always @* begin
        prio_d   = prio_q;
        enable_d = enable_q;
        flag_d   = flag_q | req_rise;
        if (wr_pend_q) begin
            case (wr_kind)
                KIND_PRIO: begin
                    prio_d[32*wr_idx_q +: 32] = hwdata & `IPF_IMPL_MASK;
                end
                KIND_FLAG: begin
                    flag_d = hwdata[NUM_SRC-1:0] | req_rise;
                end
                KIND_ENABLE: begin
                    enable_d = hwdata[NUM_SRC-1:0];
                end
                default: begin
                    enable_d = enable_q;
                end
            endcase
        end
    end

    // Read data built from next values so a read right after a write sees it.
    always @* begin
        case (rd_kind)
            KIND_PRIO: begin
                hrdata_d = prio_d[32*addr_idx +: 32] & `IPF_IMPL_MASK;
            end
            KIND_FLAG: begin
                hrdata_d = widen(flag_d);
            end
            KIND_ENABLE: begin
                hrdata_d = widen(enable_d);
            end
            KIND_STATUS: begin
                hrdata_d = status_word(present_valid_q, present_src_q, present_level_q, present_sub_q);
            end
            default: begin
                hrdata_d = `IPF_WORD_RST;
            end
        endcase
    end

    // Unpack every slot of every priority register into per-source fields.
    always @* begin
        levels = {(`IPF_PRIO_W*NUM_SRC){1'b0}};
        subs   = {(`IPF_SUB_W*NUM_SRC){1'b0}};
        for (s = 0; s < NUM_SRC; s = s + 1) begin
            levels[`IPF_PRIO_W*s +: `IPF_PRIO_W] =
                slot_prio(prio_q[32*(s/`IPF_SLOTS_PER_REG) +: 32], s[1:0]);
            subs[`IPF_SUB_W*s +: `IPF_SUB_W] =
                slot_sub(prio_q[32*(s/`IPF_SLOTS_PER_REG) +: 32], s[1:0]);
        end
    end

    // Only pending and enabled sources take part in the ranking.
    ipf_arbiter #(
        .NUM_SRC (NUM_SRC),
        .IDX_W   (IDX_W)
    ) u_arb (
        .req       (flag_q & enable_q),
        .levels    (levels),
        .subs      (subs),
        .win_valid (win_valid),
        .win_idx   (win_idx),
        .win_level (win_level),
        .win_sub   (win_sub)
    );

    // Register file: priority words, pending flags and enables.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prio_q   <= {NUM_PRIO_REGS{`IPF_WORD_RST}};
            flag_q   <= {NUM_SRC{1'b0}};
            enable_q <= {NUM_SRC{1'b0}};
        end else begin
            prio_q   <= prio_d;
            flag_q   <= flag_d;
            enable_q <= enable_d;
        end
    end

    // Previous synchronised level; it resets to the idle low level of the pins,
    // so the release of reset makes no false edge.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_dly_q <= {NUM_SRC{1'b0}};
        end else begin
            req_dly_q <= req_sync;
        end
    end

    // Bus pipeline: a write lands at the end of its data phase, and read data
    // is captured as the address phase is taken.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= {`IPF_IDX_W{1'b0}};
            hrdata_q  <= `IPF_WORD_RST;
        end else begin
            wr_pend_q <= take && hwrite;
            if (take) begin
                wr_idx_q <= addr_idx;
            end
            if (take && !hwrite) begin
                hrdata_q <= hrdata_d;
            end
        end
    end

    // Presented interrupt, one cycle behind the ranking.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            present_valid_q <= 1'b0;
            present_src_q   <= {IDX_W{1'b0}};
            present_level_q <= {`IPF_PRIO_W{1'b0}};
            present_sub_q   <= {`IPF_SUB_W{1'b0}};
        end else begin
            present_valid_q <= win_valid;
            present_src_q   <= win_idx;
            present_level_q <= win_level;
            present_sub_q   <= win_sub;
        end
    end

    assign present_valid = present_valid_q;
    assign present_src   = present_src_q;
    assign present_level = present_level_q;
    assign present_sub   = present_sub_q;
endmodule

// *** test/ipf_sva.sv ***
// Checker for the interrupt priority field block, bound to its top module.
// Assumes one AHB-Lite master making whole-word single transfers.
`timescale 1ns/10ps
`include "ipf_defs.vh"
module ipf_sva #(
    parameter NUM_PRIO_REGS = 2,
    parameter NUM_SRC       = 8,
    parameter IDX_W         = 3
) (
    // Clock and reset
    input wire                   hclk,
    input wire                   hresetn,
    // AHB-Lite slave
    input wire                   hsel,
    input wire [31:0]            haddr,
    input wire [1:0]             htrans,
    input wire                   hwrite,
    input wire [2:0]             hsize,
    input wire [31:0]            hwdata,
    input wire                   hready,
    input wire                   hreadyout,
    input wire                   hresp,
    input wire [31:0]            hrdata,
    // Requests and presentation
    input wire [NUM_SRC-1:0]     irq_pins,
    input wire                   present_valid,
    input wire [IDX_W-1:0]       present_src,
    input wire [`IPF_PRIO_W-1:0] present_level,
    input wire [`IPF_SUB_W-1:0]  present_sub
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic [5:0]  idx_q;
    logic        wr_q;
    logic        rd_q;
    logic        seen_q;
    logic [31:0] pw_q [0:NUM_PRIO_REGS-1];
    logic [31:0] pwp_q [0:NUM_PRIO_REGS-1];
    logic [31:0] en_q;
    logic [31:0] enp_q;
    wire         take = hsel & hready & (htrans == `IPF_HTRANS_NONSEQ);
    wire  [31:0] cur_w = pwp_q[present_src >> 2];
    wire  [4:0]  lsb = {present_src[1:0], 3'h0};

    // Shadow of the written words, plus a copy one cycle late to match the registered presentation.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx_q <= 6'h00;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            seen_q <= 1'b0;
            en_q <= 32'h00000000;
            enp_q <= 32'h00000000;
            for (int i = 0; i < NUM_PRIO_REGS; i++) begin
                pw_q[i] <= 32'h00000000;
                pwp_q[i] <= 32'h00000000;
            end
        end else begin
            idx_q <= haddr[7:2];
            wr_q <= take & hwrite;
            rd_q <= take & !hwrite;
            seen_q <= seen_q | (|irq_pins);
            if (wr_q && idx_q < NUM_PRIO_REGS) pw_q[idx_q] <= hwdata & `IPF_IMPL_MASK;
            if (wr_q && idx_q == `IPF_ENABLE_IDX) en_q <= hwdata;
            for (int i = 0; i < NUM_PRIO_REGS; i++) pwp_q[i] <= pw_q[i];
            enp_q <= en_q;
        end
    end

    ready_const_a: assert property (hreadyout == 1'b1) else $error("wait state inserted");
    resp_okay_a: assert property (hresp == `IPF_HRESP_OKAY) else $error("error response");
    zero_prio_a: assert property (present_valid |-> present_level != 3'h0)
        else $error("level zero presented");
    level_field_a: assert property (present_valid |-> present_level == cur_w[lsb+2 +: 3])
        else $error("presented level differs from its field");
    sub_field_a: assert property (present_valid |-> present_sub == cur_w[lsb +: 2])
        else $error("presented subpriority differs from its field");
    enable_gate_a: assert property (present_valid |-> enp_q[present_src])
        else $error("disabled source presented");
    no_request_a: assert property (!seen_q |-> !present_valid)
        else $error("presented without any request");
    prio_readback_a: assert property (rd_q && idx_q < NUM_PRIO_REGS |-> hrdata == pw_q[idx_q])
        else $error("priority word read mismatch");
    unmapped_zero_a: assert property (rd_q && idx_q >= NUM_PRIO_REGS && idx_q < `IPF_FLAG_IDX |-> hrdata == 32'h0)
        else $error("unmapped word not zero");
endmodule

bind ipf_top ipf_sva #(.NUM_PRIO_REGS(NUM_PRIO_REGS), .NUM_SRC(NUM_SRC), .IDX_W(IDX_W)) ipf_sva_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .irq_pins(irq_pins), .present_valid(present_valid), .present_src(present_src),
    .present_level(present_level), .present_sub(present_sub));

// *** test/tb_ipf_top.sv ***
// Self-checking bench for the interrupt priority field block.
// Assumes the default sizes: two priority words and eight sources.
`timescale 1ns/10ps
`include "ipf_defs.vh"
module tb_ipf_top;
    logic        hclk, hresetn, hsel, hwrite;
    logic [31:0] haddr, hwdata, rd_v, w;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  irq_pins;
    wire         hreadyout, hresp, present_valid;
    wire  [31:0] hrdata;
    wire  [2:0]  present_src, present_level;
    wire  [1:0]  present_sub;
    int          n_mismatch = 0;
    int          total_checks = 0;
    logic [31:0] rst_addr [5] = '{32'h00, 32'h04, 32'h40, 32'h44, 32'h48};

    ipf_top ipf_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .irq_pins(irq_pins), .present_valid(present_valid),
        .present_src(present_src), .present_level(present_level), .present_sub(present_sub));

    always #5 hclk = ~hclk;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // Presentation is sampled mid-cycle, two edges after the cause has landed.
    task automatic chk_pres(input logic v, input logic [2:0] s, input logic [2:0] l, input logic [1:0] b);
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        if (v) chk("presented source", {23'h0, v, s, l, b}, {23'h0, present_valid, present_src, present_level,
            present_sub});
        else chk("presented valid", 32'h0, {31'h0, present_valid});
        @(posedge hclk);
    endtask

    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
        hsel <= 1'b1;
        haddr <= addr;
        htrans <= `IPF_HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wdata;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd_v = hrdata;
    endtask

    task automatic rd(input logic [31:0] addr, input logic [31:0] exp, input string what);
        xfer(1'b0, addr, 32'h0);
        chk(what, exp, rd_v);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        n_mismatch++;
        complete_run();
    end

    initial begin
        {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata, irq_pins} = '0;
        hsize = 3'h2;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (rst_addr[i]) rd(rst_addr[i], 32'h0, "reset word");
        $display("test reset values done");
        xfer(1'b1, 32'h00, 32'hFFFFFFFF);
        rd(32'h00, 32'h1F1F1F1F, "reserved bits");
        for (int s = 0; s < 4; s++) begin
            w = 32'((s + 4) << (8 * s + 2)) | 32'((3 - s) << (8 * s));
            xfer(1'b1, 32'h04, w);
            rd(32'h04, w, "slot field");
        end
        xfer(1'b1, 32'h20, 32'hFFFFFFFF);
        rd(32'h20, 32'h0, "unmapped word");
        $display("test field layout done");
        xfer(1'b1, 32'h00, 32'h0);
        xfer(1'b1, 32'h04, 32'h1C0E0D03);
        xfer(1'b1, 32'h44, 32'h70);
        irq_pins <= 8'hF0;
        repeat (4) @(posedge hclk);
        rd(32'h40, 32'hF0, "pending flags");
        chk_pres(1'b1, 3'h6, 3'h3, 2'h2);
        xfer(1'b1, 32'h44, 32'hF0);
        chk_pres(1'b1, 3'h7, 3'h7, 2'h0);
        rd(32'h48, 32'h80070007, "status word");
        for (int l = 1; l < 8; l++) begin
            xfer(1'b1, 32'h04, 32'(l << 26) | 32'h000E0D03);
            if (l > 3) chk_pres(1'b1, 3'h7, 3'(l), 2'h0);
            else chk_pres(1'b1, 3'h6, 3'h3, 2'h2);
        end
        for (int b = 0; b < 4; b++) begin
            xfer(1'b1, 32'h04, 32'h1C0E0D03 | 32'(b << 24));
            chk_pres(1'b1, 3'h7, 3'h7, 2'(b));
        end
        xfer(1'b1, 32'h44, 32'h0);
        chk_pres(1'b0, 3'h0, 3'h0, 2'h0);
        xfer(1'b1, 32'h44, 32'h10);
        chk_pres(1'b0, 3'h0, 3'h0, 2'h0);
        xfer(1'b1, 32'h40, 32'h0);
        rd(32'h40, 32'h0, "cleared flags");
        $display("test presentation done");
        complete_run();
    end
endmodule
